// *** logic/clear_compare_decrement_ops.sv ***
// Execute stage for clear, kick, invert, compare and decrement with Avalon-MM access
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Zero work register, set zero flag
// RULE2: Kick clears watchdog, divider if assigned
// RULE3: Kick sets expiry and sleep flags high
// RULE4: Zero file register, set zero flag
// RULE5: Invert file register into chosen destination
// RULE6: Compare subtracts work from file, sets flags
// RULE7: Compare leaves both operands unchanged
// RULE8: Decrement file register into chosen destination
// RULE9: Zero flag on null result; carry means no borrow
module clear_compare_decrement_ops #(
  parameter int DATA_W = ccd_ops_pkg::DATA_W,
  parameter int FILE_DEPTH = ccd_ops_pkg::FILE_DEPTH,
  parameter int FILE_ADDR_W = ccd_ops_pkg::FILE_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_srst,
  // Avalon-MM slave
  input wire logic [ccd_ops_pkg::BUS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Hardware events on the core clock
  input wire logic i_watchdog_tick,
  input wire logic i_divider_tick,
  input wire logic i_timeout_event,
  input wire logic i_sleep_event,
  // State seen by the rest of the core
  output logic [DATA_W-1:0] o_work_register,
  output logic o_zero_flag,
  output logic o_carry_flag,
  output logic o_watchdog_expiry_flag_n,
  output logic o_sleep_flag_n,
  output logic [DATA_W-1:0] o_watchdog_counter,
  output logic [DATA_W-1:0] o_shared_divider,
  output logic o_busy
);
  import ccd_ops_pkg::*;
  // Sequencer state
  seq_state_type state_q;
  // Latched operation
  logic [2:0] op_q;
  logic [FILE_ADDR_W-1:0] op_addr_q;
  logic op_dest_q;
  // Architectural state
  logic [DATA_W-1:0] work_register_q;
  logic zero_q, carry_q, expiry_n_q, sleep_n_q;
  logic divider_assigned_q;
  logic [FILE_ADDR_W-1:0] file_addr_q;
  logic [DATA_W-1:0] watchdog_counter_q;
  logic [DATA_W-1:0] shared_divider_q;
  logic [31:0] readdata_q;
  // Memory port
  logic [FILE_ADDR_W-1:0] mem_addr;
  logic mem_wr_en;
  logic [DATA_W-1:0] mem_wr_data;
  logic [DATA_W-1:0] mem_rd_data;
  // Bus decode
  logic idle, bus_wr, wr_lane0, exec_start;
  // Execute results
  logic [DATA_W-1:0] result;
  logic [DATA_W:0] cmp_diff;
  logic res_to_work, res_to_file, res_zero, upd_zero, upd_carry, is_kick;
  logic [31:0] read_mux;

  assign idle = (state_q == ST_IDLE);
  assign bus_wr = idle && i_avs_write;
  assign wr_lane0 = bus_wr && i_avs_byteenable[0];
  // Execute needs both low lanes for opcode and address
  assign exec_start = bus_wr && (i_avs_address == OFS_EXEC) && (i_avs_byteenable[1:0] == 2'b11);

  // Waitrequest: writes go in idle, reads leave after two wait cycles
  always_comb begin
    o_avs_waitrequest = 1'b1;
    if (state_q == ST_RDONE) begin
      o_avs_waitrequest = 1'b0;
    end else if (idle && i_avs_write) begin
      o_avs_waitrequest = 1'b0;
    end
  end
  // Sequencer transitions
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (exec_start) begin
            state_q <= ST_FETCH;
          end else if (i_avs_read) begin
            state_q <= ST_BUSRD;
          end
        end
        // Operand read issued, data arrives next
        ST_FETCH: state_q <= ST_EXEC;
        ST_EXEC: state_q <= ST_IDLE;
        ST_BUSRD: state_q <= ST_RDONE;
        ST_RDONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // Operation latch on execute write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      op_q <= 3'h0;
      op_addr_q <= '0;
      op_dest_q <= 1'b0;
    end else if (exec_start) begin
      op_q <= i_avs_writedata[EXEC_OP_LSB +: 3];
      op_addr_q <= i_avs_writedata[EXEC_ADDR_LSB +: FILE_ADDR_W];
      op_dest_q <= i_avs_writedata[EXEC_DEST_BIT];
    end
  end
  // Operation results from the fetched file operand
  always_comb begin
    cmp_diff = {1'b0, mem_rd_data} - {1'b0, work_register_q};
    result = BYTE_ZERO;
    res_to_work = 1'b0;
    res_to_file = 1'b0;
    upd_zero = 1'b0;
    upd_carry = 1'b0;
    is_kick = 1'b0;
    case (op_q)
      OP_ZERO_WORK_REG: begin
        // RULE1: load zero into work
        result = BYTE_ZERO;
        res_to_work = 1'b1;
        upd_zero = 1'b1;
      end
      OP_KICK_WATCHDOG: begin
        // RULE3: of the flags, only the two low-active ones move
        is_kick = 1'b1;
      end
      OP_ZERO_FILE_REG: begin
        // RULE4: zero selected file register
        result = BYTE_ZERO;
        res_to_file = 1'b1;
        upd_zero = 1'b1;
      end
      OP_INVERT_FILE_REG: begin
        // RULE5: bitwise inverse, destination bit
        result = ~mem_rd_data;
        res_to_work = ~op_dest_q;
        res_to_file = op_dest_q;
        upd_zero = 1'b1;
      end
      OP_COMPARE_FILE_WORK: begin
        // RULE6: file minus work, flags only
        result = cmp_diff[DATA_W-1:0];
        upd_zero = 1'b1;
        upd_carry = 1'b1;
        // RULE7: neither destination written
        res_to_work = 1'b0;
        res_to_file = 1'b0;
      end
      OP_DECREMENT_FILE_REG: begin
        // RULE8: file minus one, destination bit
        result = mem_rd_data - BYTE_ONE;
        res_to_work = ~op_dest_q;
        res_to_file = op_dest_q;
        upd_zero = 1'b1;
      end
      // Unused codes do nothing
      default: result = BYTE_ZERO;
    endcase
  end
  // RULE9: null result detection
  assign res_zero = (result == BYTE_ZERO);
  // Memory port sharing between bus and execute
  always_comb begin
    mem_addr = file_addr_q;
    mem_wr_en = 1'b0;
    mem_wr_data = i_avs_writedata[DATA_W-1:0];
    if (exec_start) begin
      // Fetch the operand of the new operation
      mem_addr = i_avs_writedata[EXEC_ADDR_LSB +: FILE_ADDR_W];
    end else if (o_busy) begin // Fetch and execute both address the operand
      mem_addr = op_addr_q;
      mem_wr_en = res_to_file && (state_q == ST_EXEC);
      mem_wr_data = result;
    end else if (wr_lane0 && (i_avs_address == OFS_FILE_DATA)) begin
      mem_wr_en = 1'b1;
    end
  end
  // File register storage
  file_reg_mem #(
    .WIDTH(DATA_W),
    .DEPTH(FILE_DEPTH),
    .ADDR_W(FILE_ADDR_W)
  ) u_file_mem (
    .i_clk(i_clk),
    .i_addr(mem_addr),
    .i_wr_en(mem_wr_en),
    .i_wr_data(mem_wr_data),
    .o_rd_data(mem_rd_data)
  );
  // Work register: bus write or execute result
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      work_register_q <= BYTE_ZERO;
    end else if ((state_q == ST_EXEC) && res_to_work) begin
      work_register_q <= result;
    end else if (wr_lane0 && (i_avs_address == OFS_WORK)) begin
      work_register_q <= i_avs_writedata[DATA_W-1:0];
    end
  end
  // Zero and carry flags
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      zero_q <= 1'b0;
      carry_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      // RULE9: zero tracks result, carry is no borrow
      if (upd_zero) begin
        zero_q <= res_zero;
      end
      if (upd_carry) begin
        carry_q <= ~cmp_diff[DATA_W];
      end
    end else if (wr_lane0 && (i_avs_address == OFS_STATUS)) begin
      zero_q <= i_avs_writedata[ST_ZERO_BIT];
      carry_q <= i_avs_writedata[ST_CARRY_BIT];
    end
  end
  // Low-active flags: hardware events win over kick
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      expiry_n_q <= 1'b1;
      sleep_n_q <= 1'b1;
    end else begin
      if (i_timeout_event) begin
        expiry_n_q <= 1'b0;
      end else if ((state_q == ST_EXEC) && is_kick) begin
        // RULE3: kick raises expiry flag
        expiry_n_q <= 1'b1;
      end else if (wr_lane0 && (i_avs_address == OFS_STATUS)) begin
        expiry_n_q <= i_avs_writedata[ST_EXPIRY_BIT];
      end
      if (i_sleep_event) begin
        sleep_n_q <= 1'b0;
      end else if ((state_q == ST_EXEC) && is_kick) begin
        // RULE3: kick raises sleep flag
        sleep_n_q <= 1'b1;
      end else if (wr_lane0 && (i_avs_address == OFS_STATUS)) begin
        sleep_n_q <= i_avs_writedata[ST_SLEEP_BIT];
      end
    end
  end
  // Divider assignment and file address pointer
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      divider_assigned_q <= 1'b0;
      file_addr_q <= '0;
    end else begin
      if (wr_lane0 && (i_avs_address == OFS_STATUS)) begin
        divider_assigned_q <= i_avs_writedata[ST_ASSIGN_BIT];
      end
      if (wr_lane0 && (i_avs_address == OFS_FILE_ADDR)) begin
        file_addr_q <= i_avs_writedata[FILE_ADDR_W-1:0];
      end
    end
  end
  // Watchdog counter: kick clears, tick counts
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      watchdog_counter_q <= BYTE_ZERO;
    end else if ((state_q == ST_EXEC) && is_kick) begin
      // RULE2: kick clears watchdog counter
      watchdog_counter_q <= BYTE_ZERO;
    end else if (i_watchdog_tick) begin
      watchdog_counter_q <= watchdog_counter_q + BYTE_ONE;
    end
  end
  // Shared divider: cleared by kick only when assigned
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      shared_divider_q <= BYTE_ZERO;
    end else if ((state_q == ST_EXEC) && is_kick && divider_assigned_q) begin
      // RULE2: divider cleared when owned by watchdog
      shared_divider_q <= BYTE_ZERO;
    end else if (i_divider_tick) begin
      shared_divider_q <= shared_divider_q + BYTE_ONE;
    end
  end

  // Read data selection, unmapped reads as zero
  always_comb begin
    read_mux = WORD_ZERO;
    if (i_avs_address == OFS_EXEC) begin
      read_mux[EXEC_ADDR_LSB +: FILE_ADDR_W] = op_addr_q;
      read_mux[EXEC_DEST_BIT] = op_dest_q;
      read_mux[EXEC_OP_LSB +: 3] = op_q;
    end else if (i_avs_address == OFS_WORK) begin
      read_mux[DATA_W-1:0] = work_register_q;
    end else if (i_avs_address == OFS_STATUS) begin
      read_mux[ST_ZERO_BIT] = zero_q;
      read_mux[ST_CARRY_BIT] = carry_q;
      read_mux[ST_EXPIRY_BIT] = expiry_n_q;
      read_mux[ST_SLEEP_BIT] = sleep_n_q;
      read_mux[ST_ASSIGN_BIT] = divider_assigned_q;
    end else if (i_avs_address == OFS_FILE_ADDR) begin
      read_mux[FILE_ADDR_W-1:0] = file_addr_q;
    end else if (i_avs_address == OFS_FILE_DATA) begin
      read_mux[DATA_W-1:0] = mem_rd_data;
    end else if (i_avs_address == OFS_WATCHDOG) begin
      read_mux[DATA_W-1:0] = watchdog_counter_q;
      read_mux[WD_DIV_LSB +: DATA_W] = shared_divider_q;
    end
  end

  // Read data captured once memory data is valid
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      readdata_q <= WORD_ZERO;
    end else if (state_q == ST_BUSRD) begin
      readdata_q <= read_mux;
    end
  end

  // Outputs
  assign o_avs_readdata = readdata_q;
  assign o_work_register = work_register_q;
  assign o_zero_flag = zero_q;
  assign o_carry_flag = carry_q;
  assign o_watchdog_expiry_flag_n = expiry_n_q;
  assign o_sleep_flag_n = sleep_n_q;
  assign o_watchdog_counter = watchdog_counter_q;
  assign o_shared_divider = shared_divider_q;
  assign o_busy = (state_q == ST_FETCH) || (state_q == ST_EXEC);
endmodule : clear_compare_decrement_ops
`default_nettype wire

// *** logic/ccd_ops_pkg.sv ***
// Shared constants for the clear, compare and decrement execute block
package ccd_ops_pkg;
  // Data and file geometry
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 6;
  localparam int FILE_DEPTH = 64;
  // Bus geometry
  localparam int BUS_ADDR_W = 5;
  // Register byte addresses
  localparam logic [4:0] OFS_EXEC = 5'h00;
  localparam logic [4:0] OFS_WORK = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_FILE_ADDR = 5'h0C;
  localparam logic [4:0] OFS_FILE_DATA = 5'h10;
  localparam logic [4:0] OFS_WATCHDOG = 5'h14;
  // Execute register fields
  localparam int EXEC_ADDR_LSB = 0;
  localparam int EXEC_DEST_BIT = 6;
  localparam int EXEC_OP_LSB = 8;
  // Status register fields
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_CARRY_BIT = 1;
  localparam int ST_EXPIRY_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  localparam int ST_ASSIGN_BIT = 4;
  // Watchdog register fields
  localparam int WD_DIV_LSB = 8;
  // Operation codes
  localparam logic [2:0] OP_ZERO_WORK_REG = 3'h0;
  localparam logic [2:0] OP_KICK_WATCHDOG = 3'h1;
  localparam logic [2:0] OP_ZERO_FILE_REG = 3'h2;
  localparam logic [2:0] OP_INVERT_FILE_REG = 3'h3;
  localparam logic [2:0] OP_COMPARE_FILE_WORK = 3'h4;
  localparam logic [2:0] OP_DECREMENT_FILE_REG = 3'h5;
  // Reset and result values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_FETCH = 5'b0_0010,
    ST_EXEC = 5'b0_0100,
    ST_BUSRD = 5'b0_1000,
    ST_RDONE = 5'b1_0000
  } seq_state_type;
endpackage : ccd_ops_pkg

// *** logic/file_reg_mem.sv ***
// Single-port file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module file_reg_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int ADDR_W = 6
) (
  input wire logic i_clk,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic [WIDTH-1:0] o_rd_data
);
  // Storage array, contents undefined after power-up
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write port
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_q[i_addr] <= i_wr_data;
    end
  end

  // Registered read, old data on a same-cycle write
  always_ff @(posedge i_clk) begin
    o_rd_data <= mem_q[i_addr];
  end
endmodule : file_reg_mem
`default_nettype wire

// *** verification/ccd_ops_sva.sv ***
// Port checker for the clear, compare and decrement execute block
`timescale 1ns/1ps
`default_nettype none
module ccd_ops_sva #(
  parameter int DATA_W = 8
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [ccd_ops_pkg::BUS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic i_timeout_event,
  input wire logic i_sleep_event,
  input wire logic [DATA_W-1:0] o_work_register,
  input wire logic o_zero_flag,
  input wire logic o_carry_flag,
  input wire logic o_watchdog_expiry_flag_n,
  input wire logic o_sleep_flag_n,
  input wire logic [DATA_W-1:0] o_watchdog_counter,
  input wire logic o_busy
);
  import ccd_ops_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Operation and destination fields on the bus
  wire logic [2:0] op = i_avs_writedata[EXEC_OP_LSB+:3];
  wire logic dest = i_avs_writedata[EXEC_DEST_BIT];
  // Execute request taken this cycle
  sequence s_accept;
    i_avs_write && !o_avs_waitrequest && i_avs_address == OFS_EXEC && i_avs_byteenable[1:0] == 2'b11;
  endsequence
  // Fetch and execute, then idle
  sequence s_run;
    o_busy [*2] ##1 !o_busy;
  endsequence
  a_exec_two_cycles: assert property (s_accept |=> s_run)
    else $error("execute did not take two busy cycles");
  a_zero_work_op: assert property (s_accept ##0 op == OP_ZERO_WORK_REG |->
    ##3 o_work_register == '0 && o_zero_flag) else $error("work register not cleared");
  a_kick_counter: assert property (s_accept ##0 op == OP_KICK_WATCHDOG |->
    ##3 o_watchdog_counter == '0) else $error("watchdog counter not cleared");
  a_kick_sets_flags: assert property (s_accept ##0 op == OP_KICK_WATCHDOG ##2
    !(i_timeout_event || i_sleep_event) |=> o_watchdog_expiry_flag_n && o_sleep_flag_n)
    else $error("kick did not raise both low-active flags");
  a_kick_keeps_zc: assert property (s_accept ##0 op == OP_KICK_WATCHDOG ##3 1'b1 |->
    o_zero_flag == $past(o_zero_flag, 3) && o_carry_flag == $past(o_carry_flag, 3))
    else $error("kick changed zero or carry");
  a_zero_file_flag: assert property (s_accept ##0 op == OP_ZERO_FILE_REG |->
    ##3 o_zero_flag) else $error("zero flag not set by file clear");
  a_invert_to_file: assert property (s_accept ##0 op == OP_INVERT_FILE_REG && dest |->
    ##3 o_work_register == $past(o_work_register, 3)) else $error("invert to file touched work");
  a_compare_keeps_work: assert property (s_accept ##0 op == OP_COMPARE_FILE_WORK |->
    ##3 o_work_register == $past(o_work_register, 3)) else $error("compare changed work");
  a_compare_no_borrow: assert property (s_accept ##0 op == OP_COMPARE_FILE_WORK &&
    o_work_register == '0 |-> ##3 o_carry_flag) else $error("carry low with zero subtrahend");
  a_decrement_to_file: assert property (s_accept ##0 op == OP_DECREMENT_FILE_REG && dest |->
    ##3 o_work_register == $past(o_work_register, 3)) else $error("decrement to file touched work");
endmodule : ccd_ops_sva
bind clear_compare_decrement_ops ccd_ops_sva #(.DATA_W(DATA_W)) u_sva (.i_clk(i_clk), .i_srst(i_srst),
  .i_avs_address(i_avs_address), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
  .i_timeout_event(i_timeout_event), .i_sleep_event(i_sleep_event), .o_work_register(o_work_register),
  .o_zero_flag(o_zero_flag), .o_carry_flag(o_carry_flag), .o_watchdog_expiry_flag_n(o_watchdog_expiry_flag_n),
  .o_sleep_flag_n(o_sleep_flag_n), .o_watchdog_counter(o_watchdog_counter), .o_busy(o_busy));
`default_nettype wire

// *** verification/clear_compare_decrement_ops_bench.sv ***
// Self-checking bench for the clear, compare and decrement execute block
`timescale 1ns/1ps
`default_nettype none
module clear_compare_decrement_ops_bench;
  import ccd_ops_pkg::*;
  logic i_clk, i_srst, i_avs_read, i_avs_write, i_watchdog_tick, i_divider_tick;
  logic [4:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd;
  logic o_avs_waitrequest, o_zero_flag, o_carry_flag, o_expiry_n, o_sleep_n, o_busy;
  logic [7:0] o_work_register, o_watchdog_counter, o_shared_divider;
  // Compare operands: file side and work side
  logic [7:0] cf [5] = '{8'h34, 8'h12, 8'h80, 8'h00, 8'h00};
  logic [7:0] cw [5] = '{8'h12, 8'h34, 8'h80, 8'h00, 8'hFF};
  int fail_count = 0;
  int checked = 0;
  clear_compare_decrement_ops u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_watchdog_tick(i_watchdog_tick), .i_divider_tick(i_divider_tick), .i_timeout_event(1'b0),
    .i_sleep_event(1'b0), .o_work_register(o_work_register), .o_zero_flag(o_zero_flag),
    .o_carry_flag(o_carry_flag), .o_watchdog_expiry_flag_n(o_expiry_n), .o_sleep_flag_n(o_sleep_n),
    .o_watchdog_counter(o_watchdog_counter), .o_shared_divider(o_shared_divider), .o_busy(o_busy));
  // Verdict and end of run
  task automatic test_done();
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One Avalon-MM transfer, held until waitrequest is low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    logic ready;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk);
      ready = !o_avs_waitrequest;
      rd = o_avs_readdata;
    end while (!ready);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  // File register access through the pointer
  task automatic fset(input logic [5:0] a, input logic [7:0] v);
    bus(1'b1, OFS_FILE_ADDR, {26'h0, a});
    bus(1'b1, OFS_FILE_DATA, {24'h0, v});
  endtask : fset
  task automatic fget(input logic [5:0] a);
    bus(1'b1, OFS_FILE_ADDR, {26'h0, a});
    bus(1'b0, OFS_FILE_DATA, 32'h0000_0000);
  endtask : fget
  // Launch one operation
  task automatic exec(input logic [2:0] op, input logic dest, input logic [5:0] a);
    bus(1'b1, OFS_EXEC, {21'h0, op, 1'b0, dest, a});
  endtask : exec
  // Pulse counter ticks
  task automatic ticks(input int nw, input int nd);
    for (int i = 0; i < 4; i++) begin
      i_watchdog_tick <= (i < nw);
      i_divider_tick <= (i < nd);
      @(posedge i_clk);
    end
  endtask : ticks
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge i_clk);
    fail_count++;
    test_done();
  end
  // Main sequence
  initial begin
    i_srst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 5'h00;
    i_avs_writedata = 32'h0000_0000;
    i_watchdog_tick = 1'b0;
    i_divider_tick = 1'b0;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_000C);
    bus(1'b0, 5'h18, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Clear work register with zero flag low
    bus(1'b1, OFS_WORK, 32'h0000_0055);
    exec(OP_ZERO_WORK_REG, 1'b0, 6'h00);
    bus(1'b0, OFS_WORK, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(o_zero_flag, 1'b1);
    // Clear the top file register
    bus(1'b1, OFS_STATUS, 32'h0000_000C);
    fset(6'h3F, 8'h55);
    exec(OP_ZERO_FILE_REG, 1'b0, 6'h3F);
    fget(6'h3F);
    check(rd, 32'h0000_0000);
    check(o_zero_flag, 1'b1);
    // Invert to file, then to work
    bus(1'b1, OFS_STATUS, 32'h0000_000C);
    fset(6'h05, 8'hA6);
    bus(1'b1, OFS_WORK, 32'h0000_0033);
    exec(OP_INVERT_FILE_REG, 1'b1, 6'h05);
    fget(6'h05);
    check(rd, 32'h0000_0059);
    check(o_work_register, 8'h33);
    check(o_zero_flag, 1'b0);
    fset(6'h06, 8'hFF);
    exec(OP_INVERT_FILE_REG, 1'b0, 6'h06);
    fget(6'h06);
    check(rd, 32'h0000_00FF);
    check(o_work_register, 8'h00);
    check(o_zero_flag, 1'b1);
    // Compare table, flags from the subtraction
    for (int i = 0; i < 5; i++) begin
      fset(6'h07, cf[i]);
      bus(1'b1, OFS_WORK, {24'h0, cw[i]});
      exec(OP_COMPARE_FILE_WORK, 1'b1, 6'h07);
      fget(6'h07);
      check(rd, {24'h0, cf[i]});
      check(o_work_register, cw[i]);
      check({o_zero_flag, o_carry_flag}, {cf[i] == cw[i], cf[i] >= cw[i]});
    end
    // Decrement to file reaching zero, then to work wrapping
    fset(6'h08, 8'h01);
    exec(OP_DECREMENT_FILE_REG, 1'b1, 6'h08);
    fget(6'h08);
    check(rd, 32'h0000_0000);
    check(o_zero_flag, 1'b1);
    fset(6'h09, 8'h00);
    exec(OP_DECREMENT_FILE_REG, 1'b0, 6'h09);
    fget(6'h09);
    check(rd, 32'h0000_0000);
    check(o_work_register, 8'hFF);
    check(o_zero_flag, 1'b0);
    // Operand address differs from the bus pointer
    fset(6'h0A, 8'h10);
    fset(6'h0B, 8'h20);
    exec(OP_DECREMENT_FILE_REG, 1'b0, 6'h0A);
    bus(1'b0, OFS_WORK, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    // Kick with divider unassigned, then assigned
    bus(1'b1, OFS_STATUS, 32'h0000_0003);
    ticks(3, 2);
    exec(OP_KICK_WATCHDOG, 1'b0, 6'h00);
    bus(1'b0, OFS_WATCHDOG, 32'h0000_0000);
    check(rd, 32'h0000_0200);
    check(o_shared_divider, 8'h02);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    check({o_expiry_n, o_sleep_n}, 2'b11);
    bus(1'b1, OFS_STATUS, 32'h0000_0010);
    ticks(1, 1);
    exec(OP_KICK_WATCHDOG, 1'b0, 6'h00);
    bus(1'b0, OFS_WATCHDOG, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_001C);
    check(o_watchdog_counter, 8'h00);
    check(o_shared_divider, 8'h00);
    test_done();
  end
endmodule : clear_compare_decrement_ops_bench
`default_nettype wire
